// ### bench/pasm_lp_model.sv
// Purpose: Remote link partner as seen by the five PHY ports.
// Assumes: One clock; outputs change just after a rising edge.
// Notes:   A legacy partner does not negotiate and is found by parallel detect.
`timescale 1ns/1ps
`default_nettype none

module pasm_lp_model (
  input  wire logic       i_clk,
  input  wire logic [4:0] i_neg,
  input  wire logic [4:0] i_leg100,
  output logic [4:0]      o_an,
  output logic [4:0]      o_pd_det,
  output logic [4:0]      o_pd_100
);
  // ---------------------------------------------------------------------------
  // Partner behaviour
  // ---------------------------------------------------------------------------
  // A negotiating partner offers pause and a page; it is never parallel detected.
  always @(posedge i_clk) begin
    o_an     <= i_neg;
    o_pd_det <= ~i_neg;
    o_pd_100 <= i_leg100;
  end
endmodule : pasm_lp_model

`default_nettype wire

// ### bench/pasm_top_tb.sv
// Purpose: Self-checking bench for the five-port auxiliary registers.
// Assumes: Inputs change by non-blocking assignment at a rising edge.
// Notes:   Latched bits are checked across back-to-back reads.
`timescale 1ns/1ps
`default_nettype none
`include "pasm_regs.svh"

module pasm_top_tb import pasm_pkg::*; ;
  localparam logic [31:0] SUM = 32'(`PASM_ADDR_SUMMARY);
  localparam logic [31:0] M2  = 32'(`PASM_ADDR_MODE_TWO);
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_ce = 1'b1;
  logic        i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [31:0] i_awaddr, i_wdata, i_araddr, o_rdata, rdv;
  logic [3:0]  i_wstrb;
  logic [1:0]  o_bresp, o_rresp, rsp;
  logic [4:0]  i_an_en, i_an_done, i_enter_lgc, i_enter_ack, i_enter_abil, i_pause_local;
  logic [4:0]  i_forced_100, i_forced_fdx, i_pd_fault, i_speed_100, i_link_pass;
  logic [4:0]  i_fdx_active, i_tx_en, i_rx_dv, i_crs, i_adv_10, i_adv_100, neg, leg;
  logic [4:0]  lp, i_pd_detect, i_pd_speed_100, o_dribble_trunc, o_unlock_ext;
  logic [4:0]  o_rx_dv, o_crs, o_pd_link;
  logic [14:0] i_best_common_mode;
  logic [19:0] o_fifo_depth;
  logic [2:0]  codes [4] = '{`PASM_CODE_10HD, `PASM_CODE_10FD, `PASM_CODE_TXHD, `PASM_CODE_TXFD};
  int          fail_count = 0;
  int          checks_done = 0;

  always #5 i_clk = ~i_clk;

  pasm_top u_dut (.i_clk, .i_rst_n, .i_ce, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
    .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_an_en, .i_an_done, .i_enter_lgc,
    .i_enter_ack, .i_enter_abil, .i_pause_local, .i_pause_partner(lp), .i_best_common_mode,
    .i_forced_100, .i_forced_fdx, .i_pd_fault, .i_page_rx(lp), .i_lp_an_able(lp),
    .i_speed_100, .i_link_pass, .i_fdx_active, .i_tx_en, .i_rx_dv, .i_crs, .i_pd_detect,
    .i_pd_speed_100, .i_adv_10, .i_adv_100, .o_dribble_trunc, .o_unlock_ext, .o_fifo_depth,
    .o_rx_dv, .o_crs, .o_pd_link);

  pasm_lp_model u_lp (.i_clk, .i_neg(neg), .i_leg100(leg), .o_an(lp),
    .o_pd_det(i_pd_detect), .o_pd_100(i_pd_speed_100));

  // ---------------------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s exp %h saw %h", n, e, s);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_awaddr  <= a;
    i_wdata   <= {16'h0000, d};
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    i_bready  <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_awready && i_awvalid) i_awvalid <= 1'b0;
      if (o_wready && i_wvalid) i_wvalid <= 1'b0;
    end while (o_bvalid !== 1'b1);
    rsp = o_bresp;
    i_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a);
    @(posedge i_clk);
    i_araddr  <= a;
    i_arvalid <= 1'b1;
    i_rready  <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_arready && i_arvalid) i_arvalid <= 1'b0;
    end while (o_rvalid !== 1'b1);
    rdv = o_rdata;
    rsp = o_rresp;
    i_rready <= 1'b0;
  endtask : rd

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  initial begin
    repeat (5000) @(posedge i_clk);
    fail_count++;
    conclude();
  end

  initial begin
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_awaddr, i_wdata, i_araddr} = '0;
    {i_an_en, i_an_done, i_enter_lgc, i_enter_ack, i_enter_abil, i_pause_local} = '0;
    {i_forced_100, i_forced_fdx, i_pd_fault, i_speed_100, i_link_pass, i_fdx_active} = '0;
    {i_tx_en, i_rx_dv, i_crs, i_adv_10, i_adv_100, neg, leg, i_best_common_mode} = '0;
    i_wstrb = 4'h3;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(M2);
    chk("mode2 reset", rdv, 32'(`PASM_M2_RESET));
    wr(M2 + 32'h100, 16'h0e8a);
    rd(M2 + 32'h100);
    chk("mode2 port1", rdv, 32'h0000_0e8a);
    rd(M2);
    chk("mode2 port0", rdv, 32'(`PASM_M2_RESET));
    chk("depth", 32'(o_fifo_depth), 32'h0007_77e7);
    chk("dribble", 32'(o_dribble_trunc), 32'h0000_0002);
    chk("unlock", 32'(o_unlock_ext), 32'h0000_0002);
    $display("mode test done");
    i_an_en <= 5'h01;
    i_an_done <= 5'h01;
    i_best_common_mode <= 15'(`PASM_CODE_TXFD);
    {i_enter_lgc, i_enter_ack, i_enter_abil, i_pd_fault} <= 20'h08421;
    i_pause_local <= 5'h01;
    i_speed_100 <= 5'h01;
    i_link_pass <= 5'h01;
    i_fdx_active <= 5'h01;
    neg <= 5'h01;
    @(posedge i_clk);
    {i_enter_lgc, i_enter_ack, i_enter_abil, i_pd_fault} <= 20'h00000;
    repeat (2) @(posedge i_clk);
    rd(SUM);
    chk("summary", rdv, 32'h0000_fdba);
    rd(SUM);
    chk("summary", rdv, 32'h0000_8d3f);
    i_link_pass <= 5'h00;
    i_an_done <= 5'h00;
    @(posedge i_clk);
    i_link_pass <= 5'h01;
    repeat (2) @(posedge i_clk);
    rd(SUM);
    chk("summary", rdv, 32'h0000_083b);
    i_an_en <= 5'h00;
    i_tx_en <= 5'h01;
    for (int i = 0; i < 4; i++) begin
      i_forced_100 <= {4'h0, i[1]};
      i_forced_fdx <= {4'h0, i[0]};
      repeat (2) @(posedge i_clk);
      rd(SUM);
      chk("mode code", 32'(rdv[10:8]), 32'(codes[i]));
    end
    $display("summary test done");
    i_forced_100 <= 5'h00;
    i_forced_fdx <= 5'h00;
    repeat (3) @(posedge i_clk);
    #1;
    chk("crs", 32'(o_crs), 32'h0000_0001);
    chk("rx_dv", 32'(o_rx_dv), 32'h0000_0000);
    wr(M2, 16'h000a);
    repeat (2) @(posedge i_clk);
    i_tx_en <= 5'h00;
    #1;
    chk("rx_dv", 32'(o_rx_dv), 32'h0000_0001);
    @(posedge i_clk);
    #1;
    chk("crs", 32'(o_crs), 32'h0000_0000);
    @(posedge i_clk);
    leg <= 5'h08;
    repeat (3) @(posedge i_clk);
    chk("pd link", 32'(o_pd_link[3]), 32'h0000_0000);
    i_adv_100 <= 5'h08;
    repeat (3) @(posedge i_clk);
    chk("pd link", 32'(o_pd_link[3]), 32'h0000_0001);
    i_adv_100 <= 5'h00;
    wr(M2 + 32'h300, 16'h0088);
    repeat (3) @(posedge i_clk);
    chk("pd link", 32'(o_pd_link[3]), 32'h0000_0001);
    i_ce  <= 1'b0;
    i_crs <= 5'h01;
    repeat (3) @(posedge i_clk);
    chk("frozen crs", 32'(o_crs), 32'h0000_0000);
    i_ce  <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk("crs", 32'(o_crs), 32'h0000_0001);
    wr(SUM, 16'hffff);
    chk("summary wr resp", 32'(rsp), 32'(`PASM_RESP_OKAY));
    wr(M2 + 32'h500, 16'h008a);
    chk("unmapped wr resp", 32'(rsp), 32'(`PASM_RESP_SLVERR));
    rd(32'h0000_0010);
    chk("unmapped resp", 32'(rsp), 32'(`PASM_RESP_SLVERR));
    $display("echo and detect tests done");
    conclude();
  end
endmodule : pasm_top_tb

`default_nettype wire

// ### logic/pasm_port.sv
// Purpose: One port's status summary and mode-2 register.
// Assumes: Status inputs are on the PHY clock.
// Notes:   Latched bits show the held value; a read returns them to tracking.
`timescale 1ns/1ps
`default_nettype none
`include "pasm_regs.svh"

module pasm_port import pasm_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst_n,
  pasm_port_if.port bus
);

  logic [3:0]    lh_r;
  logic [3:0]    lh_nxt;
  logic [1:0]    ll_r;
  logic [1:0]    ll_nxt;
  pasm_word_type mode2_r;
  pasm_word_type mode2_nxt;
  wire logic [3:0] lh_ev;
  wire logic [1:0] ll_cond;
  wire logic [2:0] forced_code;
  wire logic [2:0] mode_code;

  // ----------------------------------------------------------------------------
  // Latched bits
  // ----------------------------------------------------------------------------
  // A new event in the read cycle wins over the clear.
  assign lh_ev   = {bus.stat.enter_lgc, bus.stat.enter_ack, bus.stat.enter_abil,
                    bus.stat.pd_fault};
  assign lh_nxt  = lh_ev | (lh_r & ~{4{bus.rd_clr}});
  assign ll_cond = {bus.stat.link_pass, bus.stat.fdx_active};
  assign ll_nxt  = bus.rd_clr ? ll_cond : (ll_r & ll_cond);
  assign mode2_nxt = bus.wr_en ? ((mode2_r & ~bus.wmask) | (bus.wdata & bus.wmask))
                               : mode2_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lh_r    <= 4'h0;
      ll_r    <= 2'h0;
      mode2_r <= `PASM_M2_RESET;
    end else if (bus.ce) begin
      lh_r    <= lh_nxt;
      ll_r    <= ll_nxt;
      mode2_r <= mode2_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // Summary word
  // ----------------------------------------------------------------------------
  assign forced_code = bus.stat.forced_100 ?
                       (bus.stat.forced_fdx ? `PASM_CODE_TXFD : `PASM_CODE_TXHD) :
                       (bus.stat.forced_fdx ? `PASM_CODE_10FD : `PASM_CODE_10HD);
  assign mode_code = !bus.stat.an_en ? forced_code :
                     (bus.stat.an_done ? bus.stat.best_common_mode : `PASM_CODE_NONE);

  // Fields other than the latches and the constant-zero bit 6 mirror primary status; only latches hold state here.
  assign bus.summary = {bus.stat.an_done, lh_r[3:1],
                        bus.stat.pause_local & bus.stat.pause_partner,
                        mode_code, lh_r[0], 1'b0,
                        bus.stat.page_rx, bus.stat.lp_an_able,
                        bus.stat.speed_100, ll_r[1], bus.stat.an_en, ll_r[0]};
  assign bus.mode2 = mode2_r;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  ll_fdx_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (bus.ce && !bus.stat.fdx_active) |=> !bus.summary[`PASM_SUM_FDX])
    else $error("Full-duplex loss not held low.");

  pd_fault_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (bus.ce && bus.stat.pd_fault) ##1 (!bus.ce || !bus.rd_clr)[*2]
      |-> bus.summary[`PASM_SUM_PD_FAULT])
    else $error("Parallel fault latch dropped before a read.");

endmodule : pasm_port

`default_nettype wire

// ### logic/pasm_top.sv
// Purpose: Five-port PHY auxiliary status summary and mode-2 registers over AXI4-Lite.
// Assumes: PHY status and MII signals come from logic on the same clock.
// Notes:   Port p sits at byte address p*256; registers at index*4 within it.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pasm_regs.svh"

module pasm_top import pasm_pkg::*; (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  // AXI4-Lite slave.
  input  wire logic [31:0] i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [31:0] i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // Primary PHY status, one bit per port; best common mode takes three bits per port.
  input  wire logic [4:0]  i_an_en,
  input  wire logic [4:0]  i_an_done,
  input  wire logic [4:0]  i_enter_lgc,
  input  wire logic [4:0]  i_enter_ack,
  input  wire logic [4:0]  i_enter_abil,
  input  wire logic [4:0]  i_pause_local,
  input  wire logic [4:0]  i_pause_partner,
  input  wire logic [14:0] i_best_common_mode,
  input  wire logic [4:0]  i_forced_100,
  input  wire logic [4:0]  i_forced_fdx,
  input  wire logic [4:0]  i_pd_fault,
  input  wire logic [4:0]  i_page_rx,
  input  wire logic [4:0]  i_lp_an_able,
  input  wire logic [4:0]  i_speed_100,
  input  wire logic [4:0]  i_link_pass,
  input  wire logic [4:0]  i_fdx_active,
  // Receive path and parallel detect.
  input  wire logic [4:0]  i_tx_en,
  input  wire logic [4:0]  i_rx_dv,
  input  wire logic [4:0]  i_crs,
  input  wire logic [4:0]  i_pd_detect,
  input  wire logic [4:0]  i_pd_speed_100,
  input  wire logic [4:0]  i_adv_10,
  input  wire logic [4:0]  i_adv_100,
  // Controls toward the PHY core.
  output logic [4:0]       o_dribble_trunc,
  output logic [4:0]       o_unlock_ext,
  output logic [19:0]      o_fifo_depth,
  output logic [4:0]       o_rx_dv,
  output logic [4:0]       o_crs,
  output logic [4:0]       o_pd_link
);

  // ----------------------------------------------------------------------------
  // Write and read channel state
  // ----------------------------------------------------------------------------
  logic        aw_full_r;
  logic [31:0] awaddr_r;
  logic        w_full_r;
  logic [15:0] wdata_r;
  logic [1:0]  wstrb_r;
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  wire logic       aw_take;
  wire logic       w_take;
  wire logic       wr_go;
  wire logic       b_done;
  wire logic       ar_take;
  wire logic       r_done;
  wire logic [2:0] aw_port;
  wire logic [2:0] ar_port;
  wire logic       aw_in_map;
  wire logic       ar_in_map;
  wire logic       aw_is_mode;
  wire logic       ar_is_sum;
  wire logic       ar_is_mode;
  wire logic       ar_hit;
  wire logic [15:0] wmask;
  wire logic [15:0] rd_word;

  pasm_word_type sum_w  [`PASM_NUM_PORTS];
  pasm_word_type mode_w [`PASM_NUM_PORTS];

  assign aw_take = i_ce & i_awvalid & awready_r;
  assign w_take  = i_ce & i_wvalid & wready_r;
  assign wr_go   = i_ce & aw_full_r & w_full_r & ~bvalid_r;
  assign b_done  = i_ce & bvalid_r & i_bready;
  assign ar_take = i_ce & i_arvalid & arready_r;
  assign r_done  = i_ce & rvalid_r & i_rready;

  // ----------------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------------
  assign aw_port    = awaddr_r[10:8];
  assign ar_port    = i_araddr[10:8];
  assign aw_in_map  = (awaddr_r[31:11] == 21'h0) && (aw_port < 3'h5);
  assign ar_in_map  = (i_araddr[31:11] == 21'h0) && (ar_port < 3'h5);
  assign aw_is_mode = aw_in_map && (awaddr_r[7:0] == `PASM_ADDR_MODE_TWO);
  assign ar_is_sum  = ar_in_map && (i_araddr[7:0] == `PASM_ADDR_SUMMARY);
  assign ar_is_mode = ar_in_map && (i_araddr[7:0] == `PASM_ADDR_MODE_TWO);
  assign ar_hit     = ar_is_sum | ar_is_mode;
  assign wmask      = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign rd_word    = ar_is_sum ? sum_w[ar_port] :
                      (ar_is_mode ? mode_w[ar_port] : 16'h0000);

  // ----------------------------------------------------------------------------
  // Write handshake
  // ----------------------------------------------------------------------------
  // Address and data are taken in either order; the response waits for both.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_full_r <= 1'b0;
      awaddr_r  <= 32'h0;
      awready_r <= 1'b1;
    end else if (aw_take) begin
      aw_full_r <= 1'b1;
      awaddr_r  <= i_awaddr;
      awready_r <= 1'b0;
    end else if (b_done) begin
      aw_full_r <= 1'b0;
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      w_full_r <= 1'b0;
      wdata_r  <= 16'h0;
      wstrb_r  <= 2'h0;
      wready_r <= 1'b1;
    end else if (w_take) begin
      w_full_r <= 1'b1;
      wdata_r  <= i_wdata[15:0];
      wstrb_r  <= i_wstrb[1:0];
      wready_r <= 1'b0;
    end else if (b_done) begin
      w_full_r <= 1'b0;
      wready_r <= 1'b1;
    end
  end

  // The summary is read-only, so a write to it is answered but ignored.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `PASM_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= aw_in_map ? `PASM_RESP_OKAY : `PASM_RESP_SLVERR;
    end else if (b_done) begin
      bvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Read handshake
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= `PASM_RESP_OKAY;
    end else if (ar_take) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= {16'h0000, rd_word};
      rresp_r   <= ar_hit ? `PASM_RESP_OKAY : `PASM_RESP_SLVERR;
    end else if (r_done) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  assign o_awready = awready_r;
  assign o_wready  = wready_r;
  assign o_bvalid  = bvalid_r;
  assign o_bresp   = bresp_r;
  assign o_arready = arready_r;
  assign o_rvalid  = rvalid_r;
  assign o_rdata   = rdata_r;
  assign o_rresp   = rresp_r;

  // ----------------------------------------------------------------------------
  // Ports
  // ----------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `PASM_NUM_PORTS; g = g + 1) begin : gen_port
      pasm_port_if u_if ();
      logic            hd10;
      logic            pd_ok;
      logic            rx_dv_r;
      logic            crs_r;
      logic            link_r;
      logic            drib_r;
      logic            unlk_r;
      logic [3:0]      fifo_r;

      assign u_if.ce     = i_ce;
      assign u_if.wr_en  = wr_go & aw_is_mode & (aw_port == 3'(g));
      assign u_if.wdata  = wdata_r;
      assign u_if.wmask  = wmask;
      assign u_if.rd_clr = ar_take & ar_is_sum & (ar_port == 3'(g));
      assign u_if.stat   = '{an_en: i_an_en[g], an_done: i_an_done[g],
                             enter_lgc: i_enter_lgc[g], enter_ack: i_enter_ack[g],
                             enter_abil: i_enter_abil[g], pause_local: i_pause_local[g],
                             pause_partner: i_pause_partner[g],
                             best_common_mode: i_best_common_mode[3*g +: 3],
                             forced_100: i_forced_100[g], forced_fdx: i_forced_fdx[g],
                             pd_fault: i_pd_fault[g], page_rx: i_page_rx[g],
                             lp_an_able: i_lp_an_able[g], speed_100: i_speed_100[g],
                             link_pass: i_link_pass[g], fdx_active: i_fdx_active[g]};
      assign sum_w[g]  = u_if.summary;
      assign mode_w[g] = u_if.mode2;

      pasm_port u_port (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .bus     (u_if.port)
      );

      // Echo handling only applies while running 10BASE-T half duplex.
      assign hd10  = (u_if.summary[10:8] == `PASM_CODE_10HD);
      assign pd_ok = !u_if.mode2[`PASM_M2_QUAL_PD] ? 1'b1 :
                     (i_pd_speed_100[g] ? i_adv_100[g] : i_adv_10[g]);

      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          rx_dv_r <= 1'b0;
          crs_r   <= 1'b0;
          link_r  <= 1'b0;
          drib_r  <= 1'b0;
          unlk_r  <= 1'b0;
          fifo_r  <= `PASM_FIFO_NORM;
        end else if (i_ce) begin
          rx_dv_r <= i_rx_dv[g] | (hd10 & ~u_if.mode2[`PASM_M2_ECHO_BLK] & i_tx_en[g]);
          crs_r   <= i_crs[g] | (hd10 & i_tx_en[g]);
          link_r  <= i_pd_detect[g] & pd_ok;
          drib_r  <= u_if.mode2[`PASM_M2_DRIBBLE];
          unlk_r  <= u_if.mode2[`PASM_M2_JUMBO];
          fifo_r  <= u_if.mode2[`PASM_M2_JFIFO] ? `PASM_FIFO_JUMBO : `PASM_FIFO_NORM;
        end
      end

      assign o_rx_dv[g]            = rx_dv_r;
      assign o_crs[g]              = crs_r;
      assign o_pd_link[g]          = link_r;
      assign o_dribble_trunc[g]    = drib_r;
      assign o_unlock_ext[g]       = unlk_r;
      assign o_fifo_depth[4*g +: 4] = fifo_r;
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  // Port 0 stands for all ports and port 1 for the jumbo controls; the logic is one body.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  an_done_a: assert property (sum_w[0][`PASM_SUM_AN_DONE] == i_an_done[0])
    else $error("Completion bit does not mirror status.");

  lh_entry_a: assert property ((i_ce && i_enter_lgc[0]) |=> sum_w[0][`PASM_SUM_LGC])
    else $error("Link-good-check entry not latched.");

  rd_clear_a: assert property ((gen_port[0].u_if.rd_clr && !i_enter_ack[0])
    |=> !sum_w[0][`PASM_SUM_ACK])
    else $error("Latched bit not cleared by read.");

  pause_both_a: assert property (sum_w[0][`PASM_SUM_PAUSE] ==
    (i_pause_local[0] && i_pause_partner[0]))
    else $error("Pause bit wrong.");

  forced_mode_a: assert property ((!i_an_en[0] && i_forced_100[0] && i_forced_fdx[0])
    |-> sum_w[0][10:8] == `PASM_CODE_TXFD)
    else $error("Forced mode code wrong.");

  link_low_a: assert property ((i_ce && !i_link_pass[0])
    |=> !sum_w[0][`PASM_SUM_LINK])
    else $error("Link drop not held low.");

  echo_block_a: assert property ((i_ce && gen_port[0].hd10 && i_tx_en[0]
    && mode_w[0][`PASM_M2_ECHO_BLK]) |=> (o_crs[0] && o_rx_dv[0] == $past(i_rx_dv[0])))
    else $error("Echo not moved onto carrier sense.");

  qual_pd_a: assert property ((i_ce && i_pd_detect[0] && mode_w[0][`PASM_M2_QUAL_PD]
    && !i_pd_speed_100[0] && !i_adv_10[0]) |=> !o_pd_link[0])
    else $error("Link given for unadvertised speed.");

  fifo_depth_a: assert property ((i_ce && mode_w[1][`PASM_M2_JFIFO])
    |=> o_fifo_depth[7:4] == `PASM_FIFO_JUMBO)
    else $error("Receive FIFO depth not doubled.");

  wr_resp_a: assert property (wr_go
    |=> (o_bvalid && ((o_bresp == `PASM_RESP_OKAY) == $past(aw_in_map))))
    else $error("Write response missing.");

  sum_read_c:  cover property (gen_port[0].u_if.rd_clr && sum_w[0][`PASM_SUM_LGC]);
  mode_write_c: cover property (gen_port[4].u_if.wr_en);
  bad_addr_c:  cover property (o_rvalid && o_rresp == `PASM_RESP_SLVERR);

endmodule : pasm_top

`default_nettype wire

// ### shared/pasm_pkg.sv
// Purpose: Types shared by the auxiliary register block.
// Assumes: Nothing beyond the register header.
// Notes:   The status struct carries the primary PHY status one port needs.
`default_nettype none

package pasm_pkg;

  typedef logic [15:0] pasm_word_type;

  typedef struct packed {
    logic       an_en;
    logic       an_done;
    logic       enter_lgc;
    logic       enter_ack;
    logic       enter_abil;
    logic       pause_local;
    logic       pause_partner;
    logic [2:0] best_common_mode;
    logic       forced_100;
    logic       forced_fdx;
    logic       pd_fault;
    logic       page_rx;
    logic       lp_an_able;
    logic       speed_100;
    logic       link_pass;
    logic       fdx_active;
  } pasm_stat_type;

endpackage : pasm_pkg

`default_nettype wire

// ### shared/pasm_port_if.sv
// Purpose: Carries register access and status between the bus side and one port.
// Assumes: One instance per port, all on the PHY clock.
// Notes:   The host modport drives accesses, the port modport answers.
`timescale 1ns/1ps
`default_nettype none

interface pasm_port_if;
  import pasm_pkg::*;

  logic          ce;
  logic          wr_en;
  pasm_word_type wdata;
  pasm_word_type wmask;
  logic          rd_clr;
  pasm_stat_type stat;
  pasm_word_type summary;
  pasm_word_type mode2;

  modport host (output ce, wr_en, wdata, wmask, rd_clr, stat, input summary, mode2);
  modport port (input ce, wr_en, wdata, wmask, rd_clr, stat, output summary, mode2);
endinterface : pasm_port_if

`default_nettype wire

// ### shared/pasm_regs.svh
// Purpose: Offsets, field positions, reset values and codes of the PHY auxiliary registers.
// Assumes: Included by its bare name from every file that needs it.
// Notes:   Byte address = port page times 256 plus register index times four.
`ifndef PASM_REGS_SVH
`define PASM_REGS_SVH

// ----------------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------------
`define PASM_NUM_PORTS      5
`define PASM_PAGE_LSB       8
`define PASM_IDX_SUMMARY    6'h32
`define PASM_IDX_MODE_TWO   6'h36
`define PASM_ADDR_SUMMARY   ({`PASM_IDX_SUMMARY, 2'b00})
`define PASM_ADDR_MODE_TWO  ({`PASM_IDX_MODE_TWO, 2'b00})

// ----------------------------------------------------------------------------
// Summary fields
// ----------------------------------------------------------------------------
`define PASM_SUM_AN_DONE    15
`define PASM_SUM_LGC        14
`define PASM_SUM_ACK        13
`define PASM_SUM_ABIL       12
`define PASM_SUM_PAUSE      11
`define PASM_SUM_MODE_HI    10
`define PASM_SUM_MODE_LO    8
`define PASM_SUM_PD_FAULT   7
`define PASM_SUM_PAGE_RX    5
`define PASM_SUM_LP_AN      4
`define PASM_SUM_SPEED      3
`define PASM_SUM_LINK       2
`define PASM_SUM_AN_EN      1
`define PASM_SUM_FDX        0

// Operating mode codes.
`define PASM_CODE_NONE      3'b000
`define PASM_CODE_10HD      3'b001
`define PASM_CODE_10FD      3'b010
`define PASM_CODE_TXHD      3'b011
`define PASM_CODE_T4        3'b100
`define PASM_CODE_TXFD      3'b101

// ----------------------------------------------------------------------------
// Mode-2 fields
// ----------------------------------------------------------------------------
`define PASM_M2_DRIBBLE     11
`define PASM_M2_JUMBO       10
`define PASM_M2_JFIFO       9
`define PASM_M2_ECHO_BLK    7
`define PASM_M2_QUAL_PD     1
`define PASM_M2_RESET       16'h008a
`define PASM_FIFO_NORM      4'h7
`define PASM_FIFO_JUMBO     4'he

// Bus responses.
`define PASM_RESP_OKAY      2'h0
`define PASM_RESP_SLVERR    2'h2

`endif
